// ==== rtl/urs_cfg.svh ====
// Register offsets, field positions, reset values and sampling points
// Assumes inclusion by bare name from every receiver design file
`ifndef URS_CFG_SVH
`define URS_CFG_SVH

// Register offsets on the plain register port
`define URS_ADDR_CTRL      4'h0
`define URS_ADDR_DATA      4'h1
`define URS_ADDR_IRQ       4'h2
`define URS_ADDR_DIVL      4'h3
`define URS_ADDR_DIVH      4'h4

// Fields of receive_status_control
`define URS_BIT_PORT_EN    7
`define URS_BIT_NINE_EN    6
`define URS_BIT_CONT_EN    4
`define URS_BIT_ADDR_EN    3
`define URS_BIT_FRAME_ERR  2
`define URS_BIT_OVERRUN    1
`define URS_BIT_NINTH      0

// Fields of interrupt_control_reg
`define URS_BIT_AVAIL      0
`define URS_BIT_RXIE       1
`define URS_BIT_PERIE      2
`define URS_BIT_GLBIE      3

// Oversampling points within one bit time
`define URS_OS_FIRST       4'h0
`define URS_OS_LAST        4'hf
`define URS_SAMPLE_A       4'h7
`define URS_SAMPLE_B       4'h8
`define URS_SAMPLE_C       4'h9

// Indices of the first and last data bits
`define URS_LAST_IDX8      4'h7
`define URS_LAST_IDX9      4'h8
`define URS_IDX_FIRST      4'h0

// Reset values
`define URS_RST_BYTE       8'h00
`define URS_RST_DIV        16'h0000
`define URS_RST_CHAR       9'h000
`define URS_RST_ONES       2'h0
`define URS_LINE_IDLE      1'b1

`endif

// ==== rtl/urs_pkg.sv ====
// Types shared by the receiver files
// Assumes nothing of its surroundings
package urs_pkg;

  typedef enum logic [1:0] {
    URS_IDLE  = 2'b00,
    URS_START = 2'b01,
    URS_DATA  = 2'b10,
    URS_STOP  = 2'b11
  } urs_state_e;

  typedef struct packed {
    logic       framing_error_flag;
    logic [8:0] data;
  } urs_char_s;

endpackage : urs_pkg

// ==== rtl/urs_bit_recovery.sv ====
// Serial bit recovery: line synchroniser, 16x tick, start check, framing
// Assumes an idle-high line and a divider held stable while receiving
`timescale 1ns/1ps
`include "urs_cfg.svh"

module urs_bit_recovery #(
  parameter int DIV_W = 16
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rstn,
  // Control
  input  wire logic             unit_clear,
  input  wire logic             rx_enable,
  input  wire logic             nine_bit,
  input  wire logic [DIV_W-1:0] baud_div,
  // Serial line
  input  wire logic             rx_pin,
  // Received character
  output logic                  char_valid,
  output logic [8:0]            char_data,
  output logic                  char_framing_error_flag
);

  logic                  sync1_reg;
  logic                  sync2_reg;
  logic                  sync3_reg;
  logic                  lvl_reg;
  logic                  lvl_next;
  logic [DIV_W-1:0]      div_cnt_reg;
  logic [DIV_W-1:0]      div_cnt_next;
  urs_pkg::urs_state_e   state_reg;
  urs_pkg::urs_state_e   state_next;
  logic [3:0]            os_reg;
  logic [3:0]            os_next;
  logic [1:0]            ones_reg;
  logic [1:0]            ones_next;
  logic [3:0]            idx_reg;
  logic [3:0]            idx_next;
  logic [8:0]            shift_reg;
  logic [8:0]            shift_next;
  logic                  valid_reg;
  logic                  valid_next;
  logic [8:0]            data_reg;
  logic [8:0]            data_next;
  logic                  framing_error_flag_reg;
  logic                  framing_error_flag_next;
  logic                  tick;
  logic                  fall;
  logic                  sample_hit;
  logic                  bit_end;
  logic                  bit_val;

  function automatic logic majority(input logic [1:0] ones, input logic s);
    logic [1:0] sum;
    sum = ones + {1'b0, s};
    return sum[1];
  endfunction : majority

  assign tick       = (div_cnt_reg == baud_div);
  assign fall       = lvl_reg && !lvl_next;
  assign sample_hit = tick && (os_reg == `URS_SAMPLE_C);
  assign bit_end    = tick && (os_reg == `URS_OS_LAST);
  assign bit_val    = majority(ones_reg, lvl_reg);

  always_comb begin
    // Level counts once second and third stages agree
    lvl_next     = (sync2_reg == sync3_reg) ? sync3_reg : lvl_reg;
    div_cnt_next = tick ? '0 : div_cnt_reg + 1'b1;
    state_next   = state_reg;
    os_next      = os_reg;
    ones_next    = ones_reg;
    idx_next     = idx_reg;
    shift_next   = shift_reg;
    valid_next   = 1'b0;
    data_next    = data_reg;
    framing_error_flag_next    = framing_error_flag_reg;
    if (tick && (state_reg != urs_pkg::URS_IDLE)) begin
      os_next = os_reg + 4'h1;
      if ((os_reg == `URS_SAMPLE_A) || (os_reg == `URS_SAMPLE_B)) begin
        ones_next = ones_reg + {1'b0, lvl_reg};
      end
      if (os_reg == `URS_SAMPLE_C) begin
        ones_next = `URS_RST_ONES;
      end
    end
    unique case (state_reg)
      urs_pkg::URS_IDLE: begin
        if (fall) begin
          state_next = urs_pkg::URS_START;
          os_next    = `URS_OS_FIRST;
          ones_next  = `URS_RST_ONES;
          shift_next = `URS_RST_CHAR;
        end
      end
      urs_pkg::URS_START: begin
        if (sample_hit && bit_val) begin
          state_next = urs_pkg::URS_IDLE;
        end else if (bit_end) begin
          state_next = urs_pkg::URS_DATA;
          idx_next   = `URS_IDX_FIRST;
        end
      end
      urs_pkg::URS_DATA: begin
        if (sample_hit) begin
          shift_next[idx_reg] = bit_val;
        end
        if (bit_end) begin
          if (idx_reg == (nine_bit ? `URS_LAST_IDX9 : `URS_LAST_IDX8)) begin
            state_next = urs_pkg::URS_STOP;
          end else begin
            idx_next = idx_reg + 4'h1;
          end
        end
      end
      urs_pkg::URS_STOP: begin
        if (sample_hit) begin
          valid_next = 1'b1;
          data_next  = shift_reg;
          framing_error_flag_next  = !bit_val;
          state_next = urs_pkg::URS_IDLE;
        end
      end
    endcase
    if (!rx_enable || unit_clear) begin
      state_next = urs_pkg::URS_IDLE;
      valid_next = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      sync1_reg   <= `URS_LINE_IDLE;
      sync2_reg   <= `URS_LINE_IDLE;
      sync3_reg   <= `URS_LINE_IDLE;
      lvl_reg     <= `URS_LINE_IDLE;
      div_cnt_reg <= '0;
      state_reg   <= urs_pkg::URS_IDLE;
      os_reg      <= `URS_OS_FIRST;
      ones_reg    <= `URS_RST_ONES;
      idx_reg     <= `URS_IDX_FIRST;
      shift_reg   <= `URS_RST_CHAR;
      valid_reg   <= 1'b0;
      data_reg    <= `URS_RST_CHAR;
      framing_error_flag_reg    <= 1'b0;
    end else begin
      sync1_reg   <= rx_pin;
      sync2_reg   <= sync1_reg;
      sync3_reg   <= sync2_reg;
      lvl_reg     <= lvl_next;
      div_cnt_reg <= div_cnt_next;
      state_reg   <= state_next;
      os_reg      <= os_next;
      ones_reg    <= ones_next;
      idx_reg     <= idx_next;
      shift_reg   <= shift_next;
      valid_reg   <= valid_next;
      data_reg    <= data_next;
      framing_error_flag_reg    <= framing_error_flag_next;
    end
  end

  assign char_valid = valid_reg;
  assign char_data  = data_reg;
  assign char_framing_error_flag  = framing_error_flag_reg;

endmodule : urs_bit_recovery

// ==== rtl/urs_receiver.sv ====
// Asynchronous receiver: control and status registers, receive FIFO,
// overrun, address filter and receive interrupt request
// Assumes a single-cycle strobe register master on the same clock
//
// Overview of operation
// - Available flag high while receiver enabled and FIFO holds unread characters
// - Available flag is read-only; only FIFO occupancy and the port and receive enables drive it
// - Interrupt request needs receive, peripheral and global enables all set
// - Available flag ignores every interrupt enable
// - Each FIFO entry keeps its framing error; status shows oldest entry
// - Reception continues after framing error; data read pops and advances status
// - Port enable low clears framing errors; receive enable low keeps them
// - Framing errors alone never request an interrupt
// - Two-entry FIFO; third complete character while full sets overrun
// - During overrun stored characters stay readable, new ones are dropped
// - Overrun clears when receive enable or port enable goes low
// - Nine-bit mode shifts and stores nine data bits
// - Ninth bit of oldest entry shown in status, read before data
// - Address filter in nine-bit mode keeps only ninth-bit-set characters
// - Bits recovered at sixteen samples per bit with majority at centre
// - Start edge rechecked at half bit; high line silently abandons character
// - Stop sample low marks framing error, high marks clean character
`timescale 1ns/1ps
`include "urs_cfg.svh"

module urs_receiver #(
  parameter int DEPTH = 2,
  parameter int DIV_W = 16
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rstn,
  // Register port
  input  wire logic [3:0] addr,
  input  wire logic [7:0] wr_data,
  input  wire logic       wr_en,
  input  wire logic       rd_en,
  output logic      [7:0] rd_data,
  // Serial line
  input  wire logic       rx_pin,
  // Status
  output logic            rx_irq,
  output logic            rx_avail
);

  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CNT_W = $clog2(DEPTH + 1);
  localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(DEPTH);

  // Configuration state
  logic              port_en_reg;
  logic              port_en_next;
  logic              nine_en_reg;
  logic              nine_en_next;
  logic              cont_en_reg;
  logic              cont_en_next;
  logic              addr_en_reg;
  logic              addr_en_next;
  logic              rxie_reg;
  logic              rxie_next;
  logic              perie_reg;
  logic              perie_next;
  logic              glbie_reg;
  logic              glbie_next;
  logic [DIV_W-1:0]  div_reg;
  logic [DIV_W-1:0]  div_next;

  // Receive FIFO state
  urs_pkg::urs_char_s mem_reg [DEPTH];
  urs_pkg::urs_char_s mem_next [DEPTH];
  logic [PTR_W-1:0]  wr_ptr_reg;
  logic [PTR_W-1:0]  wr_ptr_next;
  logic [PTR_W-1:0]  rd_ptr_reg;
  logic [PTR_W-1:0]  rd_ptr_next;
  logic [CNT_W-1:0]  count_reg;
  logic [CNT_W-1:0]  count_next;
  logic              overrun_reg;
  logic              overrun_next;

  // Output state
  logic [7:0]        rd_data_reg;
  logic [7:0]        rd_data_next;
  logic              irq_reg;
  logic              irq_next;
  logic              avail_reg;
  logic              avail_next;

  // Recovered character
  logic              char_valid;
  logic [8:0]        char_data;
  logic              char_framing_error_flag;

  logic              unit_clear;
  logic              nonempty;
  logic              avail;
  logic              pop;
  logic              keep;
  logic              push;
  logic              overflow;
  logic              head_framing_error_flag;
  logic              head_ninth;
  urs_pkg::urs_char_s head;

  function automatic logic [PTR_W-1:0] next_ptr(input logic [PTR_W-1:0] p);
    return (p == PTR_W'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction : next_ptr

  function automatic logic hit(input logic [3:0] a, input logic [3:0] target);
    return a == target;
  endfunction : hit

  urs_bit_recovery #(
    .DIV_W (DIV_W)
  ) u_recovery (
    .clk        (clk),
    .rstn       (rstn),
    .unit_clear (unit_clear),
    .rx_enable  (port_en_reg && cont_en_reg),
    .nine_bit   (nine_en_reg),
    .baud_div   (div_reg),
    .rx_pin     (rx_pin),
    .char_valid (char_valid),
    .char_data  (char_data),
    .char_framing_error_flag  (char_framing_error_flag)
  );

  assign unit_clear = !port_en_reg;
  assign nonempty   = (count_reg != '0);
  assign head       = mem_reg[rd_ptr_reg];
  assign avail      = port_en_reg && cont_en_reg && nonempty;
  assign head_framing_error_flag  = nonempty && head.framing_error_flag;
  assign head_ninth = nonempty && head.data[8];
  assign pop        = rd_en && hit(addr, `URS_ADDR_DATA) && nonempty;
  // Address filter drops characters with ninth bit clear
  assign keep       = char_valid && !(addr_en_reg && nine_en_reg && !char_data[8]);
  assign overflow   = keep && !overrun_reg && (count_reg == FULL_CNT) && !pop;
  assign push       = keep && !overrun_reg && !overflow;

  // Configuration writes
  always_comb begin
    port_en_next = port_en_reg;
    nine_en_next = nine_en_reg;
    cont_en_next = cont_en_reg;
    addr_en_next = addr_en_reg;
    rxie_next    = rxie_reg;
    perie_next   = perie_reg;
    glbie_next   = glbie_reg;
    div_next     = div_reg;
    if (wr_en) begin
      unique case (addr)
        `URS_ADDR_CTRL: begin
          // Status bits are read-only; only control bits take writes
          port_en_next = wr_data[`URS_BIT_PORT_EN];
          nine_en_next = wr_data[`URS_BIT_NINE_EN];
          cont_en_next = wr_data[`URS_BIT_CONT_EN];
          addr_en_next = wr_data[`URS_BIT_ADDR_EN];
        end
        `URS_ADDR_IRQ: begin
          rxie_next  = wr_data[`URS_BIT_RXIE];
          perie_next = wr_data[`URS_BIT_PERIE];
          glbie_next = wr_data[`URS_BIT_GLBIE];
        end
        `URS_ADDR_DIVL: begin
          div_next[7:0] = wr_data;
        end
        `URS_ADDR_DIVH: begin
          div_next[DIV_W-1:8] = wr_data[DIV_W-9:0];
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      port_en_reg <= 1'b0;
      nine_en_reg <= 1'b0;
      cont_en_reg <= 1'b0;
      addr_en_reg <= 1'b0;
      rxie_reg    <= 1'b0;
      perie_reg   <= 1'b0;
      glbie_reg   <= 1'b0;
      div_reg     <= `URS_RST_DIV;
    end else begin
      port_en_reg <= port_en_next;
      nine_en_reg <= nine_en_next;
      cont_en_reg <= cont_en_next;
      addr_en_reg <= addr_en_next;
      rxie_reg    <= rxie_next;
      perie_reg   <= perie_next;
      glbie_reg   <= glbie_next;
      div_reg     <= div_next;
    end
  end

  // Receive FIFO and overrun
  always_comb begin
    mem_next     = mem_reg;
    wr_ptr_next  = wr_ptr_reg;
    rd_ptr_next  = rd_ptr_reg;
    count_next   = count_reg + CNT_W'(push) - CNT_W'(pop);
    overrun_next = overrun_reg;
    if (push) begin
      mem_next[wr_ptr_reg].data = char_data;
      mem_next[wr_ptr_reg].framing_error_flag = char_framing_error_flag;
      wr_ptr_next               = next_ptr(wr_ptr_reg);
    end
    if (pop) begin
      rd_ptr_next = next_ptr(rd_ptr_reg);
    end
    // Overrun set wins over the receive-enable clear in the same cycle; port disable clears it regardless
    if (overflow) begin
      overrun_next = 1'b1;
    end else if (!cont_en_reg) begin
      overrun_next = 1'b0;
    end
    if (unit_clear) begin
      wr_ptr_next  = '0;
      rd_ptr_next  = '0;
      count_next   = '0;
      overrun_next = 1'b0;
      for (int i = 0; i < DEPTH; i++) begin
        mem_next[i] = '0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      wr_ptr_reg  <= '0;
      rd_ptr_reg  <= '0;
      count_reg   <= '0;
      overrun_reg <= 1'b0;
      for (int i = 0; i < DEPTH; i++) begin
        mem_reg[i] <= '0;
      end
    end else begin
      wr_ptr_reg  <= wr_ptr_next;
      rd_ptr_reg  <= rd_ptr_next;
      count_reg   <= count_next;
      overrun_reg <= overrun_next;
      mem_reg     <= mem_next;
    end
  end

  // Read data, interrupt request and available flag
  always_comb begin
    rd_data_next = `URS_RST_BYTE;
    if (rd_en) begin
      unique case (addr)
        `URS_ADDR_CTRL: begin
          rd_data_next[`URS_BIT_PORT_EN]   = port_en_reg;
          rd_data_next[`URS_BIT_NINE_EN]   = nine_en_reg;
          rd_data_next[`URS_BIT_CONT_EN]   = cont_en_reg;
          rd_data_next[`URS_BIT_ADDR_EN]   = addr_en_reg;
          rd_data_next[`URS_BIT_FRAME_ERR] = head_framing_error_flag;
          rd_data_next[`URS_BIT_OVERRUN]   = overrun_reg;
          rd_data_next[`URS_BIT_NINTH]     = head_ninth;
        end
        `URS_ADDR_DATA: begin
          rd_data_next = nonempty ? head.data[7:0] : `URS_RST_BYTE;
        end
        `URS_ADDR_IRQ: begin
          rd_data_next[`URS_BIT_AVAIL] = avail;
          rd_data_next[`URS_BIT_RXIE]  = rxie_reg;
          rd_data_next[`URS_BIT_PERIE] = perie_reg;
          rd_data_next[`URS_BIT_GLBIE] = glbie_reg;
        end
        `URS_ADDR_DIVL: begin
          rd_data_next = div_reg[7:0];
        end
        `URS_ADDR_DIVH: begin
          rd_data_next = div_reg[DIV_W-1:8];
        end
        default: begin
          rd_data_next = `URS_RST_BYTE;
        end
      endcase
    end
    // Only the available condition can raise a request
    irq_next   = avail && rxie_reg && perie_reg && glbie_reg;
    avail_next = avail;
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      rd_data_reg <= `URS_RST_BYTE;
      irq_reg     <= 1'b0;
      avail_reg   <= 1'b0;
    end else begin
      rd_data_reg <= rd_data_next;
      irq_reg     <= irq_next;
      avail_reg   <= avail_next;
    end
  end

  assign rd_data  = rd_data_reg;
  assign rx_irq   = irq_reg;
  assign rx_avail = avail_reg;

endmodule : urs_receiver

// ==== verification/urs_receiver_properties.sv ====
// Concurrent checks on the receiver's ports, bound into every receiver
// Assumes a single-strobe register master and shadows enables from writes
`timescale 1ns/1ps
`include "urs_cfg.svh"

module urs_receiver_properties (
  // Clock and reset
  input wire logic       clk,
  input wire logic       rstn,
  // Register port
  input wire logic [3:0] addr,
  input wire logic [7:0] wr_data,
  input wire logic       wr_en,
  input wire logic       rd_en,
  input wire logic [7:0] rd_data,
  // Serial line and status
  input wire logic       rx_pin,
  input wire logic       rx_irq,
  input wire logic       rx_avail
);
  logic [7:0] ctrl_reg;
  logic [7:0] ctrl_next;
  logic [2:0] ie_reg;
  logic [2:0] ie_next;
  logic       run;
  logic       rd_ctrl;

  // Shadow of the writable enables
  always_comb begin
    ctrl_next = ctrl_reg;
    ie_next   = ie_reg;
    if (wr_en && addr == `URS_ADDR_CTRL) begin
      ctrl_next = wr_data;
    end
    if (wr_en && addr == `URS_ADDR_IRQ) begin
      ie_next = wr_data[3:1];
    end
  end
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ctrl_reg <= 8'h00;
      ie_reg   <= 3'h0;
    end else begin
      ctrl_reg <= ctrl_next;
      ie_reg   <= ie_next;
    end
  end
  assign run     = ctrl_reg[7] & ctrl_reg[4];
  assign rd_ctrl = rd_en && addr == `URS_ADDR_CTRL;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  avail_needs_run_a: assert property (!run && !$past(run) |-> !rx_avail)
    else $error("available flag high while receiver disabled");
  avail_fall_cause_a: assert property ($fell(rx_avail) && $past(rstn) |->
    $past(rd_en) || $past(rd_en, 2) || $past(wr_en) || $past(wr_en, 2))
    else $error("available flag fell without a read or control write");
  irq_needs_avail_a: assert property (rx_irq |-> rx_avail)
    else $error("interrupt request without available flag");
  irq_needs_enables_a: assert property (rx_irq |-> (&ie_reg) || $past(&ie_reg))
    else $error("interrupt request with an enable cleared");
  irq_follows_avail_a: assert property (rx_avail && $past(rx_avail) &&
    (&ie_reg) && $past(&ie_reg) |-> rx_irq)
    else $error("interrupt request missing with all enables set");
  flag_read_back_a: assert property ($past(rd_en && addr == `URS_ADDR_IRQ) |->
    rd_data == {4'h0, $past(ie_reg), rx_avail})
    else $error("interrupt register read mismatch");
  overrun_clear_a: assert property ($past(rd_ctrl) && !$past(run) &&
    !$past(run, 2) && !$past(run, 3) |-> !rd_data[1])
    else $error("overrun still set while reception disabled");
  port_clear_a: assert property ($past(rd_ctrl) && !$past(ctrl_reg[7]) &&
    !$past(ctrl_reg[7], 2) |-> rd_data[2:0] == 3'h0)
    else $error("status bits set while port disabled");
  ctrl_read_back_a: assert property ($past(rd_ctrl) |->
    rd_data[7:3] == ($past(ctrl_reg[7:3]) & 5'h1b))
    else $error("control read back mismatch");

  cover property (rx_irq);
  cover property ($past(rd_ctrl) && rd_data[1]);
  cover property ($past(rd_ctrl) && rd_data[2]);
endmodule : urs_receiver_properties

bind urs_receiver urs_receiver_properties props_u (.clk(clk), .rstn(rstn), .addr(addr),
  .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .rx_pin(rx_pin),
  .rx_irq(rx_irq), .rx_avail(rx_avail));

// ==== verification/urs_line_driver.sv ====
// Model of the far serial transmitter driving the receive line
// Assumes the bench calls its tasks and sets the bit length in clocks
`timescale 1ns/1ps

module urs_line_driver #(
  parameter int BIT_CLKS = 32
) (
  // Clock
  input wire logic clk,
  // Serial line
  output logic     rx_pin
);
  initial rx_pin = 1'b1;

  task automatic hold_bit(input logic v);
    rx_pin <= v;
    repeat (BIT_CLKS) @(posedge clk);
  endtask : hold_bit

  // Whole frame, then one idle bit
  task automatic send(input logic [8:0] d, input logic nine, input logic bad);
    @(posedge clk);
    hold_bit(1'b0);
    for (int i = 0; i < (nine ? 9 : 8); i++) begin
      hold_bit(d[i]);
    end
    hold_bit(!bad);
    hold_bit(1'b1);
  endtask : send

  // Short low pulse, gone before the start centre
  // Idle long enough that a wrongly kept start would deliver a character
  task automatic glitch;
    @(posedge clk);
    rx_pin <= 1'b0;
    repeat (BIT_CLKS / 4) @(posedge clk);
    repeat (10) hold_bit(1'b1);
  endtask : glitch
endmodule : urs_line_driver

// ==== verification/urs_receiver_tb.sv ====
// Self-checking bench: register tasks and serial traffic into the receiver
// Assumes the line driver model and divider 1, so 32 clocks per bit
`timescale 1ns/1ps
`include "urs_cfg.svh"

module urs_receiver_tb;
  logic       clk;
  logic       rstn;
  logic [3:0] addr;
  logic [7:0] wr_data;
  logic       wr_en;
  logic       rd_en;
  logic [7:0] rd_data;
  logic       rx_pin;
  logic       rx_irq;
  logic       rx_avail;
  int         miscompares;
  int         num_checks;

  urs_receiver dut_u (.clk(clk), .rstn(rstn), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .rx_pin(rx_pin),
    .rx_irq(rx_irq), .rx_avail(rx_avail));
  urs_line_driver #(.BIT_CLKS(32)) line_u (.clk(clk), .rx_pin(rx_pin));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic chk8(input logic [3:0] a, input logic [7:0] exp, input logic [7:0] act);
    num_checks++;
    if (act !== exp) begin
      miscompares++;
      $display("unexpected reg %h: expected %h seen %h", a, exp, act);
    end
  endtask : chk8

  task automatic chk1(input string what, input logic exp, input logic act);
    num_checks++;
    if (act !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %b seen %b", what, exp, act);
    end
  endtask : chk1

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    wr_en   <= 1'b1;
    addr    <= a;
    wr_data <= d;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk);
    rd_en <= 1'b1;
    addr  <= a;
    @(posedge clk);
    rd_en <= 1'b0;
    @(negedge clk);
    chk8(a, exp, rd_data);
  endtask : rd

  task automatic flags(input logic av, input logic irq);
    repeat (3) @(negedge clk);
    chk1("rx_avail", av, rx_avail);
    chk1("rx_irq", irq, rx_irq);
  endtask : flags

  task automatic done(input string t);
    $display("test %s finished", t);
  endtask : done

  task automatic report_and_stop;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    repeat (30000) @(posedge clk);
    miscompares++;
    report_and_stop();
  end

  initial begin
    {rstn, addr, wr_data, wr_en, rd_en} = '0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    wr(`URS_ADDR_DIVL, 8'h01);
    wr(`URS_ADDR_DIVH, 8'h00);
    wr(`URS_ADDR_CTRL, 8'h80);
    wr(`URS_ADDR_IRQ, 8'h0e);
    wr(`URS_ADDR_CTRL, 8'h90);
    rd(4'hf, 8'h00);
    line_u.send(9'h0a5, 1'b0, 1'b0);
    flags(1'b1, 1'b1);
    rd(`URS_ADDR_IRQ, 8'h0f);
    wr(`URS_ADDR_IRQ, 8'h0e);
    rd(`URS_ADDR_IRQ, 8'h0f);
    rd(`URS_ADDR_CTRL, 8'h90);
    rd(`URS_ADDR_DATA, 8'ha5);
    flags(1'b0, 1'b0);
    done("basic");
    line_u.send(9'h03c, 1'b0, 1'b1);
    line_u.send(9'h05a, 1'b0, 1'b0);
    rd(`URS_ADDR_CTRL, 8'h94);
    rd(`URS_ADDR_DATA, 8'h3c);
    rd(`URS_ADDR_CTRL, 8'h90);
    rd(`URS_ADDR_DATA, 8'h5a);
    wr(`URS_ADDR_IRQ, 8'h0f);
    rd(`URS_ADDR_IRQ, 8'h0e);
    flags(1'b0, 1'b0);
    done("framing");
    for (int i = 1; i < 4; i++) begin
      wr(`URS_ADDR_IRQ, 8'h0e & ~(8'h01 << i));
      line_u.send(9'h0f0, 1'b0, 1'b1);
      flags(1'b1, 1'b0);
      rd(`URS_ADDR_CTRL, 8'h94);
      rd(`URS_ADDR_DATA, 8'hf0);
    end
    wr(`URS_ADDR_IRQ, 8'h0e);
    done("gating");
    line_u.send(9'h001, 1'b0, 1'b0);
    line_u.send(9'h002, 1'b0, 1'b0);
    line_u.send(9'h003, 1'b0, 1'b0);
    rd(`URS_ADDR_CTRL, 8'h92);
    rd(`URS_ADDR_DATA, 8'h01);
    line_u.send(9'h004, 1'b0, 1'b0);
    rd(`URS_ADDR_DATA, 8'h02);
    rd(`URS_ADDR_CTRL, 8'h92);
    rd(`URS_ADDR_DATA, 8'h00);
    flags(1'b0, 1'b0);
    wr(`URS_ADDR_CTRL, 8'h80);
    rd(`URS_ADDR_CTRL, 8'h80);
    wr(`URS_ADDR_CTRL, 8'h90);
    line_u.send(9'h005, 1'b0, 1'b0);
    rd(`URS_ADDR_DATA, 8'h05);
    done("overrun");
    wr(`URS_ADDR_CTRL, 8'hd8);
    line_u.send(9'h012, 1'b1, 1'b0);
    line_u.send(9'h1c3, 1'b1, 1'b0);
    rd(`URS_ADDR_CTRL, 8'hd9);
    rd(`URS_ADDR_DATA, 8'hc3);
    wr(`URS_ADDR_CTRL, 8'hd0);
    line_u.send(9'h034, 1'b1, 1'b0);
    rd(`URS_ADDR_CTRL, 8'hd0);
    rd(`URS_ADDR_DATA, 8'h34);
    wr(`URS_ADDR_CTRL, 8'h90);
    done("nine_bit");
    line_u.send(9'h077, 1'b0, 1'b1);
    wr(`URS_ADDR_CTRL, 8'h80);
    rd(`URS_ADDR_CTRL, 8'h84);
    flags(1'b0, 1'b0);
    wr(`URS_ADDR_CTRL, 8'h00);
    rd(`URS_ADDR_CTRL, 8'h00);
    wr(`URS_ADDR_CTRL, 8'h90);
    rd(`URS_ADDR_DATA, 8'h00);
    done("port_reset");
    line_u.glitch();
    flags(1'b0, 1'b0);
    rd(`URS_ADDR_DATA, 8'h00);
    done("glitch");
    report_and_stop();
  end
endmodule : urs_receiver_tb
